// ### rtl/muldiv_unit.v
// Multiply/divide and shift/normalize co-processor with its register port
`timescale 1ns/1ps
`include "muldiv_defines.vh"

// Summary of operation
// - Writing byte 5 or the control register at the end of loading launches the job.
// - A byte 2 or 3 write during loading selects 32 by 16 division.
// - A byte 4 write selects 16/16 division; a byte 1 write selects 16x16 multiply.
// - Once launched the unit computes alone while the processor keeps running.
// - Division 32/16 takes 17 cycles, 16/16 takes 9, multiplication 11.
// - Shift takes 3 cycles at count 1, up to 18 cycles at count 31.
// - Normalize takes 4 to 19 cycles depending on the shifts done.
// - Quotient in bytes 0-3 or 0-1, remainder 4-5, product or shifted value 0-3.
// - Result bytes read in any order; byte 5 or byte 3 read ends the job.
// - Normalize shifts left until byte 3 bit 7 is one, storing the shift number.
// - Control bit 5 picks shift direction, bits 4-0 the count, never zero for shifts.
// - Shifting fills vacated bits with zeros at the top or the bottom.
// - Error detection arms on byte 0 write, disarms on the final result read.
// - Any register write during execution sets the error flag and interrupts the job.
// - Operand reads during execution with detection armed set error, job continues.
// - Error flag is read-only and clears only when the control register is read.
// - Overflow on divide by zero, product above FFFFh, or normalize of set top bit.
// - Other operations clear overflow; software writes never change it.
// - Control: bit 6 overflow, bit 5 direction, bits 4-0 count, zero means normalize.
module muldiv_unit (
   input wire clk_sys, // System clock
   input wire rst_b, // Asynchronous reset, active low
   input wire [2:0] addr, // Register index
   input wire [7:0] wr_data, // Write data
   input wire wr_en, // Write strobe
   input wire rd_en, // Read strobe
   output reg [7:0] rd_data, // Read data, valid the cycle after rd_en
   output wire busy // High while a calculation executes
);

   // Bus decode
   wire wr_op;
   wire wr_ctl;
   wire rd_op;
   wire rd_ctl;
   wire wr_any;
   wire wr_first;
   wire in_load;
   wire in_busy;
   wire in_result;
   wire launch;
   wire done;
   wire final_rd;
   wire set_err;
   wire [2:0] final_addr;

   // Operand views and arithmetic
   wire [47:0] opb_flat;
   wire [31:0] val32;
   wire [15:0] num1;
   wire [15:0] num2;
   wire [31:0] prod;
   wire [31:0] quo32;
   wire [31:0] rem32;
   wire [15:0] quo16;
   wire [15:0] rem16;
   wire [4:0] lz;
   wire [5:0] count_half;
   wire [5:0] lz_half;

   // Sequencer state
   reg [1:0] phase_r;
   reg [1:0] phase_nxt;
   reg [1:0] op_r;
   reg seen_hi_r;
   reg seen_mul_r;
   reg [5:0] cnt_r;
   reg [5:0] cnt_nxt;

   // Control fields and flags
   reg armed_r;
   reg err_r;
   reg ov_r;
   reg dir_r;
   reg [4:0] count_r;

   // Combinational helpers
   reg [47:0] res_nxt;
   reg ov_nxt;
   reg [5:0] launch_cnt;
   reg [1:0] launch_op;
   reg [7:0] rd_nxt;

   genvar g;

   // Unmapped index 7 is neither written nor counted as a register access
   assign wr_op = wr_en && (addr <= `MULDIV_A_BYTE5);
   assign wr_ctl = wr_en && (addr == `MULDIV_A_CTRL);
   assign rd_op = rd_en && (addr <= `MULDIV_A_BYTE5);
   assign rd_ctl = rd_en && (addr == `MULDIV_A_CTRL);
   assign wr_any = wr_op || wr_ctl;
   assign wr_first = wr_op && (addr == `MULDIV_A_BYTE0);

   assign in_load = (phase_r == `MULDIV_PH_LOAD);
   assign in_busy = (phase_r == `MULDIV_PH_BUSY);
   assign in_result = (phase_r == `MULDIV_PH_RESULT);

   assign launch = in_load && (wr_ctl || (wr_op && (addr == `MULDIV_A_BYTE5)));
   // A write in the last busy cycle aborts, so no result may land then
   assign done = in_busy && (cnt_r == 6'h01) && !wr_any;

   assign final_addr = ((op_r == `MULDIV_OP_DIV32) || (op_r == `MULDIV_OP_DIV16)) ?
      `MULDIV_A_BYTE5 : `MULDIV_A_BYTE3;
   assign final_rd = rd_op && in_result && (addr == final_addr);

   // Writes always disturb a run; reads only while detection is armed
   assign set_err = (in_busy && wr_any) || (in_busy && rd_op && armed_r);

   assign busy = in_busy;

   // Operand byte storage, one register per byte
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_opb
         localparam [2:0] IDX = g;
         reg [7:0] byte_r;
         always @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
               byte_r <= 8'h00;
            end else if (wr_op && (addr == IDX)) begin
               byte_r <= wr_data;
            end else if (done) begin
               byte_r <= res_nxt[8 * g +: 8];
            end
         end
         assign opb_flat[8 * g +: 8] = byte_r;
      end
   endgenerate

   assign val32 = opb_flat[31:0];
   assign num1 = opb_flat[15:0];
   assign num2 = opb_flat[47:32];

   // Single-cycle arithmetic; the run counter only paces the answer
   assign prod = num1 * num2;
   assign quo32 = val32 / num2;
   assign rem32 = val32 % num2;
   assign quo16 = num1 / num2;
   assign rem16 = num1 % num2;

   assign lz = lead_zeros(val32);
   assign count_half = ({1'b0, wr_data[4:0]} + 6'h01) >> 1;
   assign lz_half = ({1'b0, lz} + 6'h01) >> 1;

   // Count of leading zeros; an all-zero value stops at the field maximum
   function [4:0] lead_zeros;
      input [31:0] v;
      integer i;
      reg found;
      begin
         lead_zeros = 5'h1F;
         found = 1'b0;
         for (i = 31; i >= 0; i = i - 1) begin
            if (!found && v[i]) begin
               lead_zeros = 5'h1F - i[4:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   // Operation chosen by the load order, and its run length
   always @* begin
      launch_op = `MULDIV_OP_DIV16;
      launch_cnt = `MULDIV_CYC_DIV16;
      if (wr_ctl) begin
         launch_op = `MULDIV_OP_SHNORM;
         if (wr_data[4:0] != 5'h00) begin
            launch_cnt = `MULDIV_CYC_SHIFT_BASE + count_half;
         end else if (lz_half == 6'h00) begin
            launch_cnt = `MULDIV_CYC_NORM_MIN;
         end else begin
            launch_cnt = `MULDIV_CYC_NORM_BASE + lz_half;
         end
      end else if (seen_hi_r) begin
         launch_op = `MULDIV_OP_DIV32;
         launch_cnt = `MULDIV_CYC_DIV32;
      end else if (seen_mul_r) begin
         launch_op = `MULDIV_OP_MUL;
         launch_cnt = `MULDIV_CYC_MUL;
      end
   end

   // Result and overflow computed from the held operands at completion
   always @* begin
      res_nxt = opb_flat;
      ov_nxt = 1'b0;
      case (op_r)
         `MULDIV_OP_DIV32: begin
            if (num2 == 16'h0000) begin
               ov_nxt = 1'b1;
            end else begin
               res_nxt[31:0] = quo32;
               res_nxt[47:32] = rem32[15:0];
            end
         end
         `MULDIV_OP_DIV16: begin
            if (num2 == 16'h0000) begin
               ov_nxt = 1'b1;
            end else begin
               res_nxt[15:0] = quo16;
               res_nxt[47:32] = rem16;
            end
         end
         `MULDIV_OP_MUL: begin
            res_nxt[31:0] = prod;
            ov_nxt = (prod > `MULDIV_MUL_LIMIT);
         end
         `MULDIV_OP_SHNORM: begin
            if (count_r == 5'h00) begin
               res_nxt[31:0] = val32 << lz;
               ov_nxt = val32[31];
            end else if (dir_r) begin
               res_nxt[31:0] = val32 >> count_r;
            end else begin
               res_nxt[31:0] = val32 << count_r;
            end
         end
         default: begin
            ov_nxt = 1'b0;
         end
      endcase
   end

   // Phase sequencer
   always @* begin
      phase_nxt = phase_r;
      case (phase_r)
         `MULDIV_PH_IDLE: begin
            if (wr_first) begin
               phase_nxt = `MULDIV_PH_LOAD;
            end
         end
         `MULDIV_PH_LOAD: begin
            if (wr_first) begin
               phase_nxt = `MULDIV_PH_LOAD;
            end else if (launch) begin
               phase_nxt = `MULDIV_PH_BUSY;
            end
         end
         `MULDIV_PH_BUSY: begin
            // A byte 0 write mid-run is also a restart of loading
            if (wr_first) begin
               phase_nxt = `MULDIV_PH_LOAD;
            end else if (wr_any) begin
               phase_nxt = `MULDIV_PH_IDLE;
            end else if (cnt_r == 6'h01) begin
               phase_nxt = `MULDIV_PH_RESULT;
            end
         end
         `MULDIV_PH_RESULT: begin
            if (wr_first) begin
               phase_nxt = `MULDIV_PH_LOAD;
            end else if (final_rd) begin
               phase_nxt = `MULDIV_PH_IDLE;
            end
         end
         default: begin
            phase_nxt = `MULDIV_PH_IDLE;
         end
      endcase
   end

   // Run counter; reads never stop it
   always @* begin
      cnt_nxt = cnt_r;
      if (launch) begin
         cnt_nxt = launch_cnt;
      end else if (in_busy && wr_any) begin
         cnt_nxt = 6'h00;
      end else if (in_busy) begin
         cnt_nxt = cnt_r - 6'h01;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= `MULDIV_PH_IDLE;
         cnt_r <= 6'h00;
      end else begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Operation latched at launch
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         op_r <= `MULDIV_OP_DIV16;
      end else if (launch) begin
         op_r <= launch_op;
      end
   end

   // Load-order memory; the later of byte 1 and byte 4 picks the 16-bit job
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         seen_hi_r <= 1'b0;
         seen_mul_r <= 1'b0;
      end else if (wr_first) begin
         seen_hi_r <= 1'b0;
         seen_mul_r <= 1'b0;
      end else if (in_load && wr_op) begin
         if ((addr == `MULDIV_A_BYTE2) || (addr == `MULDIV_A_BYTE3)) begin
            seen_hi_r <= 1'b1;
         end
         if (addr == `MULDIV_A_BYTE1) begin
            seen_mul_r <= 1'b1;
         end else if (addr == `MULDIV_A_BYTE4) begin
            seen_mul_r <= 1'b0;
         end
      end
   end

   // Error detection arming
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_r <= 1'b0;
      end else if (wr_first) begin
         armed_r <= 1'b1;
      end else if (final_rd) begin
         armed_r <= 1'b0;
      end
   end

   // Error flag; setting event wins over the clearing read
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         err_r <= 1'b0;
      end else if (set_err) begin
         err_r <= 1'b1;
      end else if (rd_ctl) begin
         err_r <= 1'b0;
      end
   end

   // Overflow moves only on completion; an aborted run leaves it alone
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ov_r <= 1'b0;
      end else if (done) begin
         ov_r <= ov_nxt;
      end
   end

   // Direction and count fields
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dir_r <= 1'b0;
         count_r <= 5'h00;
      end else if (wr_ctl) begin
         dir_r <= wr_data[`MULDIV_CTL_DIR];
         count_r <= wr_data[`MULDIV_CTL_CNT_HI:`MULDIV_CTL_CNT_LO];
      end else if (done && (op_r == `MULDIV_OP_SHNORM) && (count_r == 5'h00)) begin
         count_r <= lz;
      end
   end

   // Read data; flags show their value before a clearing read
   always @* begin
      rd_nxt = 8'h00;
      if (rd_ctl) begin
         rd_nxt = {err_r, ov_r, dir_r, count_r};
      end else if (rd_op) begin
         rd_nxt = opb_flat[8 * addr +: 8];
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= rd_nxt;
      end
   end

endmodule // muldiv_unit

// ### rtl/muldiv_defines.vh
// Register map, field positions, op codes and cycle counts of the multiply/divide unit
`ifndef MULDIV_DEFINES_VH
`define MULDIV_DEFINES_VH

// Register indices on the plain register port
`define MULDIV_A_BYTE0 3'h0
`define MULDIV_A_BYTE1 3'h1
`define MULDIV_A_BYTE2 3'h2
`define MULDIV_A_BYTE3 3'h3
`define MULDIV_A_BYTE4 3'h4
`define MULDIV_A_BYTE5 3'h5
`define MULDIV_A_CTRL 3'h6

// Control register fields
`define MULDIV_CTL_ERR 7
`define MULDIV_CTL_OV 6
`define MULDIV_CTL_DIR 5
`define MULDIV_CTL_CNT_HI 4
`define MULDIV_CTL_CNT_LO 0
`define MULDIV_CTL_RESET 8'h00

// Sequencer phases
`define MULDIV_PH_IDLE 2'h0
`define MULDIV_PH_LOAD 2'h1
`define MULDIV_PH_BUSY 2'h2
`define MULDIV_PH_RESULT 2'h3

// Operations
`define MULDIV_OP_DIV32 2'h0
`define MULDIV_OP_DIV16 2'h1
`define MULDIV_OP_MUL 2'h2
`define MULDIV_OP_SHNORM 2'h3

// Execution times in clock cycles
`define MULDIV_CYC_DIV32 6'h11
`define MULDIV_CYC_DIV16 6'h09
`define MULDIV_CYC_MUL 6'h0B
`define MULDIV_CYC_SHIFT_BASE 6'h02
`define MULDIV_CYC_NORM_BASE 6'h03
`define MULDIV_CYC_NORM_MIN 6'h04

// Largest product that does not overflow
`define MULDIV_MUL_LIMIT 32'h0000FFFF

`endif

// ### dv/muldiv_unit_props.sv
// Port assertions for the multiply/divide unit
`timescale 1ns/1ps
module muldiv_unit_props (
   input wire clk_sys, // System clock
   input wire rst_b, // Reset, active low
   input wire [2:0] addr, // Register index
   input wire [7:0] wr_data, // Write data
   input wire wr_en, // Write strobe
   input wire rd_en, // Read strobe
   input wire [7:0] rd_data, // Read data
   input wire busy // Run in progress
);
   reg ld_r; // Load phase open
   reg [1:0] op_r; // 0 div32, 1 div16, 2 multiply
   wire go_w = wr_en && !busy && ld_r && addr == 3'h5;
   wire goc_w = wr_en && !busy && ld_r && addr == 3'h6;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Last of byte 1 or byte 4 decides, unless byte 2 or 3 was seen
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ld_r <= 1'b0;
         op_r <= 2'h1;
      end else if (wr_en) begin
         ld_r <= !busy && (addr == 3'h0 || (ld_r && addr != 3'h5 && addr != 3'h6));
         if (addr == 3'h2 || addr == 3'h3) op_r <= 2'h0;
         else if (addr == 3'h0) op_r <= 2'h1;
         else if (op_r != 2'h0 && (addr == 3'h1 || addr == 3'h4)) op_r <= {addr == 3'h1, addr == 3'h4};
      end
   end
   a_div32_time: assert property (go_w && op_r == 2'h0 |=> busy[*8] ##1 busy[*8] ##1 busy ##1 !busy)
      else $error("div32 run length wrong");
   a_div16_time: assert property (go_w && op_r == 2'h1 |=> busy[*4] ##1 busy[*5] ##1 !busy)
      else $error("div16 run length wrong");
   a_mul_time: assert property (go_w && op_r == 2'h2 |=> busy[*6] ##1 busy[*5] ##1 !busy)
      else $error("multiply run length wrong");
   a_shift_min: assert property (goc_w && wr_data[4:0] == 5'h01 |=> busy[*3] ##1 !busy)
      else $error("short shift length wrong");
   a_shift_max: assert property (goc_w && wr_data[4:0] == 5'h1F |=> busy[*8] ##1 busy[*8] ##1 busy[*2] ##1 !busy)
      else $error("long shift length wrong");
   a_norm_range: assert property (goc_w && wr_data[4:0] == 5'h00 |=> busy[*4] ##[1:16] !busy)
      else $error("normalize length out of range");
   a_no_launch: assert property (wr_en && !busy && !go_w && !goc_w |=> !busy)
      else $error("run started without launch");
   a_abort_run: assert property (wr_en && addr != 3'h7 && busy |=> !busy)
      else $error("write in run did not abort");
   a_err_clear: assert property (rd_en && addr == 3'h6 && !busy ##1 !wr_en && !rd_en ##1 rd_en && addr == 3'h6 && !wr_en
      |=> !rd_data[7])
      else $error("error flag not cleared by read");
endmodule // muldiv_unit_props
bind muldiv_unit muldiv_unit_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .busy(busy));

// ### dv/muldiv_unit_tb.sv
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
module muldiv_unit_tb;
   reg clk_sys = 1'b0;
   reg rst_b = 1'b0;
   reg [2:0] addr = 3'h0;
   reg [7:0] wr_data = 8'h00;
   reg wr_en = 1'b0;
   reg rd_en = 1'b0;
   wire [7:0] rd_data;
   wire busy;
   integer err_count = 0;
   integer checked = 0;
   integer k, n, j;
   reg [31:0] seed = 32'h32AE48F9;
   reg [31:0] x, y, r;
   reg [7:0] md [0:5];
   reg [7:0] c;
   reg [5:0] shift_cnt = 6'h00;
   reg ov_m = 1'b0;
   reg err_m = 1'b0;
   always #2.5 clk_sys = ~clk_sys;
   muldiv_unit u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .busy(busy));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      begin
         addr <= a;
         wr_data <= d;
         wr_en <= 1'b1;
         rd_en <= 1'b0;
         if (a < 3'h6) md[a] = d;
         if (a == 3'h6) shift_cnt = d[5:0];
         @(posedge clk_sys);
      end
   endtask
   task rd(input [2:0] a, input [7:0] e);
      begin
         addr <= a;
         rd_en <= 1'b1;
         wr_en <= 1'b0;
         @(posedge clk_sys);
         rd_en <= 1'b0;
         @(negedge clk_sys);
         chk(rd_data, e);
         @(posedge clk_sys);
      end
   endtask
   // Load order picks the operation: mul writes byte 1 after byte 4
   task load(input [1:0] op, input [31:0] a, input [15:0] b);
      begin
         wr(3'h0, a[7:0]);
         if (op != 2'h2) wr(3'h1, a[15:8]);
         if (op == 2'h0 || op == 2'h3) wr(3'h2, a[23:16]);
         if (op == 2'h0 || op == 2'h3) wr(3'h3, a[31:24]);
         if (op != 2'h3) wr(3'h4, b[7:0]);
         if (op == 2'h2) wr(3'h1, a[15:8]);
         if (op != 2'h3) wr(3'h5, b[15:8]);
         else wr(3'h6, c);
      end
   endtask
   task finish(input [1:0] op);
      begin
         wr_en <= 1'b0;
         rd_en <= 1'b0;
         n = 0;
         @(negedge clk_sys);
         while (busy !== 1'b0 && n < 40) begin
            @(negedge clk_sys);
            n = n + 1;
         end
         if (n == 40) err_count = err_count + 1;
         @(posedge clk_sys);
         x = {md[3], md[2], md[1], md[0]};
         y = {16'h0000, md[5], md[4]};
         r = 32'h00000000;
         ov_m = (op < 2'h2 && y == 0) || (op == 2'h3 && shift_cnt[4:0] == 5'h00 && x[31]);
         if (op == 2'h0 && y != 0) begin
            r = x % y;
            x = x / y;
         end
         if (op == 2'h1 && y != 0) begin
            r = x[15:0] % y;
            x[15:0] = x[15:0] / y;
         end
         if (op < 2'h2 && y != 0) {md[5], md[4]} = r[15:0];
         if (op == 2'h2) x = x[15:0] * y;
         if (op == 2'h2) ov_m = x > 32'h0000FFFF;
         if (op == 2'h3 && shift_cnt[4:0] != 5'h00) x = shift_cnt[5] ? x >> shift_cnt[4:0] : x << shift_cnt[4:0];
         for (n = 0; op == 2'h3 && shift_cnt[4:0] == 5'h00 && n < 31 && !x[31]; n = n + 1) x = x << 1;
         if (op == 2'h3 && shift_cnt[4:0] == 5'h00) shift_cnt[4:0] = n[4:0];
         {md[3], md[2], md[1], md[0]} = x;
         for (j = 0; j < 6; j = j + 1) rd(j[2:0], md[j]);
         rd(3'h6, {err_m, ov_m, shift_cnt});
         err_m = 1'b0;
      end
   endtask
   task give_verdict;
      begin
         $display("checks %0d errors %0d", checked, err_count);
         if (err_count == 0 && checked > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      #100000;
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      for (k = 0; k < 6; k = k + 1) md[k] = 8'h00;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      for (k = 0; k < 8; k = k + 1) rd(k[2:0], 8'h00);
      for (k = 0; k < 16; k = k + 1) begin
         seed = lfsr(seed);
         x = seed;
         seed = lfsr(seed);
         y = seed;
         c = {2'b00, y[16], k == 3 ? 5'h01 : (k == 7 ? 5'h1F : 5'h00)};
         if (k == 6) {x[15:8], y[15:8]} = 16'h0000;
         if (k == 8) y[15:0] = 16'h0000;
         if (k == 11) x = x >> x[4:0];
         if (k == 15) x[31] = 1'b1;
         load(k[1:0], x, y[15:0]);
         finish(k[1:0]);
      end
      wr(3'h6, 8'hC0);
      rd(3'h6, 8'h40);
      c = 8'h05;
      load(2'h3, 32'h11111111, 16'h0000);
      wr(3'h6, 8'h25);
      wr_en <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk({7'h00, busy}, 8'h00);
      for (k = 0; k < 6; k = k + 1) rd(k[2:0], md[k]);
      rd(3'h6, {1'b1, ov_m, 6'h25});
      rd(3'h6, {1'b0, ov_m, 6'h25});
      load(2'h2, 32'h00001234, 16'h00AB);
      rd(3'h0, md[0]);
      err_m = 1'b1;
      finish(2'h2);
      give_verdict;
   end
endmodule // muldiv_unit_tb
